// >>> hw/ucd_ep_ctrl.sv
// Purpose: control and isochronous endpoint handling with wishbone registers
// Assumes: token, fetch and frame-start strobes come from core_clk logic
// Notes: every write and read is answered one cycle after the request
`timescale 1ns/1ns
module ucd_ep_ctrl
    import ucd_pkg::*;
#(
    parameter int NUM_EP = UCD_NUM_EP
)
(
    input logic core_clk,
    input logic reset,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [UCD_AW-1:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input logic tok_valid_i,
    input ucd_tok_t tok_i,
    input logic sof_i,
    input logic [NUM_EP-1:0] fetch_done_i,
    input logic [NUM_EP-1:0] fetch_ok_i,
    input logic [NUM_EP-1:0] next_linked_i,
    output logic [NUM_EP-1:0] prime_pending_o,
    output logic resp_valid_o,
    output ucd_resp_t resp_code_o,
    output logic setup_store_o,
    output logic [UCD_EP_W-1:0] setup_store_ep_o,
    output logic [NUM_EP-1:0] iso_retire_o,
    output logic sys_error_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic mode_reg, trip_reg, sys_err_reg;
    logic [NUM_EP-1:0] sstat_reg, prime_reg, primed_ctl_reg, txn_err_reg, buf_err_reg;
    logic [UCD_CFG_STRIDE*NUM_EP-1:0] cfg_reg;
    logic [2*NUM_EP-1:0] ovr_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic resp_valid_reg, store_reg;
    ucd_resp_t resp_code_reg, rsp_next;
    logic [UCD_EP_W-1:0] store_ep_reg;
    logic [NUM_EP-1:0] iso_primed, iso_ret, iso_terr, iso_berr, iso_vec;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire bus_wr = bus_req & wb_we_i;
    wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wr_bits = wb_dat_i & lane_mask;
    wire wr_mode = bus_wr && wb_adr_i == UCD_MODE_OFS;
    wire wr_cmd = bus_wr && wb_adr_i == UCD_CMD_OFS;
    wire wr_sstat = bus_wr && wb_adr_i == UCD_SSTAT_OFS;
    wire wr_prime = bus_wr && wb_adr_i == UCD_PRIME_OFS;
    wire wr_flush = bus_wr && wb_adr_i == UCD_PRIMED_OFS;
    wire wr_cfg = bus_wr && wb_adr_i == UCD_CFG_OFS;
    wire wr_ovr = bus_wr && wb_adr_i == UCD_OVR_OFS;
    wire wr_err = bus_wr && wb_adr_i == UCD_ERR_OFS;
    wire [NUM_EP-1:0] low_bits = wr_bits[NUM_EP-1:0];
    wire [NUM_EP-1:0] flush_vec = wr_flush ? low_bits : '0;
    wire [NUM_EP-1:0] primed_all = primed_ctl_reg | iso_primed;
    wire [31:0] err_word = 32'(txn_err_reg) | (32'(buf_err_reg) << UCD_ERR_BUF_LSB)
        | (32'(sys_err_reg) << UCD_ERR_SYS_BIT);
    wire [31:0] rd_data =
        (wb_adr_i == UCD_MODE_OFS) ? 32'(mode_reg) :
        (wb_adr_i == UCD_CMD_OFS) ? 32'(trip_reg) :
        (wb_adr_i == UCD_SSTAT_OFS) ? 32'(sstat_reg) :
        (wb_adr_i == UCD_PRIME_OFS) ? 32'(prime_reg) :
        (wb_adr_i == UCD_PRIMED_OFS) ? 32'(primed_all) :
        (wb_adr_i == UCD_CFG_OFS) ? 32'(cfg_reg) :
        (wb_adr_i == UCD_OVR_OFS) ? 32'(ovr_reg) :
        (wb_adr_i == UCD_ERR_OFS) ? err_word : 32'h0;

    // ------------------------------------------------------------
    // token decode
    // ------------------------------------------------------------
    wire [UCD_EP_W-1:0] ep = tok_i.ep;
    wire ep_iso = cfg_reg[ep*UCD_CFG_STRIDE+UCD_CFG_ISO_BIT];
    wire ep_stall = cfg_reg[ep*UCD_CFG_STRIDE+UCD_CFG_STALL_BIT];
    wire ep_primed = primed_all[ep];
    wire iso_live = ep_primed & ~ep_stall;
    wire is_in = tok_i.kind == UCD_TOK_IN;
    wire is_out = tok_i.kind == UCD_TOK_OUT;
    wire ep_bit_ok = 32'(ep) < NUM_EP;
    // lockout only while mode bit is zero
    wire lock_on = ~mode_reg & sstat_reg[ep];
    wire tok_setup = tok_valid_i && ep_bit_ok && tok_i.kind == UCD_TOK_SETUP && !ep_iso;
    wire setup_take = tok_setup & ~lock_on & ~tok_i.overflow;
    wire setup_fault = tok_setup & ~lock_on & tok_i.overflow;
    wire [NUM_EP-1:0] ep_one = NUM_EP'(1) << ep;
    wire [NUM_EP-1:0] setup_vec = setup_take ? ep_one : '0;
    wire ctl_end = tok_valid_i && ep_bit_ok && !ep_iso && !ep_stall && ep_primed && tok_i.last
        && ((is_in && !tok_i.underflow) || (is_out && !tok_i.overflow));
    wire [NUM_EP-1:0] ctl_end_vec = ctl_end ? ep_one : '0;
    wire iso_pkt = tok_valid_i && ep_bit_ok && ep_iso && iso_live && ((is_in && !tok_i.underflow) || is_out);
    wire [NUM_EP-1:0] iso_pkt_vec = iso_pkt ? ep_one : '0;
    wire [NUM_EP-1:0] fetch_good = fetch_done_i & fetch_ok_i;

    // ------------------------------------------------------------
    // token response
    // ------------------------------------------------------------
    always_comb
    begin
        rsp_next = UCD_RSP_NONE;
        if (tok_valid_i && ep_bit_ok && ep_iso)
        begin
            unique case (tok_i.kind)
                UCD_TOK_SETUP: rsp_next = UCD_RSP_STALL;
                UCD_TOK_IN: rsp_next = !iso_live ? UCD_RSP_ZLP : tok_i.underflow ? UCD_RSP_BSERR : UCD_RSP_XMIT;
                UCD_TOK_OUT: rsp_next = !iso_live ? UCD_RSP_NONE : tok_i.overflow ? UCD_RSP_DROP : UCD_RSP_RECV;
                default: rsp_next = UCD_RSP_NONE;
            endcase
        end
        else if (tok_valid_i && ep_bit_ok)
        begin
            unique case (tok_i.kind)
                UCD_TOK_SETUP: rsp_next = lock_on ? UCD_RSP_NONE : tok_i.overflow ? UCD_RSP_SYSFAULT : UCD_RSP_ACK;
                UCD_TOK_IN: rsp_next = ep_stall ? UCD_RSP_STALL : !ep_primed ? UCD_RSP_NAK
                    : tok_i.underflow ? UCD_RSP_BSERR : UCD_RSP_XMIT;
                UCD_TOK_OUT: rsp_next = ep_stall ? UCD_RSP_STALL : !ep_primed ? UCD_RSP_NAK
                    : tok_i.overflow ? UCD_RSP_NAK : tok_i.more_pkts ? UCD_RSP_ACK : UCD_RSP_NYET;
                UCD_TOK_PING: rsp_next = ep_stall ? UCD_RSP_STALL : !ep_primed ? UCD_RSP_NAK : UCD_RSP_ACK;
                default: rsp_next = UCD_RSP_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    // write one clears, setup wins
    wire [NUM_EP-1:0] sstat_next = (sstat_reg & ~(wr_sstat ? low_bits : '0)) | setup_vec;
    wire [NUM_EP-1:0] prime_next = (prime_reg & ~fetch_done_i) | (wr_prime ? low_bits : '0);
    // setup unprimes, failed fetch stays clear
    wire [NUM_EP-1:0] primed_ctl_next = (primed_ctl_reg & ~setup_vec & ~ctl_end_vec & ~flush_vec)
        | (fetch_good & ~iso_vec & ~setup_vec);
    wire trip_next = setup_take ? 1'b0 : wr_cmd ? wr_bits[UCD_CMD_TRIP_BIT] : trip_reg;
    wire mode_next = wr_mode ? wr_bits[UCD_MODE_LOCK_OFF_BIT] : mode_reg;
    wire [UCD_CFG_STRIDE*NUM_EP-1:0] cfg_mask = wr_cfg ? lane_mask[UCD_CFG_STRIDE*NUM_EP-1:0] : '0;
    wire [UCD_CFG_STRIDE*NUM_EP-1:0] cfg_next = (cfg_reg & ~cfg_mask)
        | (wb_dat_i[UCD_CFG_STRIDE*NUM_EP-1:0] & cfg_mask);
    wire [2*NUM_EP-1:0] ovr_mask = wr_ovr ? lane_mask[2*NUM_EP-1:0] : '0;
    wire [2*NUM_EP-1:0] ovr_next = (ovr_reg & ~ovr_mask) | (wb_dat_i[2*NUM_EP-1:0] & ovr_mask);
    wire [NUM_EP-1:0] txn_next = (txn_err_reg & ~(wr_err ? low_bits : '0)) | iso_terr;
    wire [NUM_EP-1:0] buf_next = (buf_err_reg & ~(wr_err ? wr_bits[UCD_ERR_BUF_LSB+:NUM_EP] : '0)) | iso_berr;
    wire sys_next = (sys_err_reg & ~(wr_err & wr_bits[UCD_ERR_SYS_BIT])) | setup_fault;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ack_reg <= 1'b0;
            dat_reg <= UCD_REG_RESET;
        end
        else
        begin
            ack_reg <= bus_req;
            dat_reg <= bus_req ? rd_data : dat_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mode_reg <= 1'b0;
            trip_reg <= 1'b0;
            sstat_reg <= '0;
            prime_reg <= '0;
            primed_ctl_reg <= '0;
        end
        else
        begin
            mode_reg <= mode_next;
            trip_reg <= trip_next;
            sstat_reg <= sstat_next;
            prime_reg <= prime_next;
            primed_ctl_reg <= primed_ctl_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_reg <= '0;
            ovr_reg <= '0;
            txn_err_reg <= '0;
            buf_err_reg <= '0;
            sys_err_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            ovr_reg <= ovr_next;
            txn_err_reg <= txn_next;
            buf_err_reg <= buf_next;
            sys_err_reg <= sys_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            resp_valid_reg <= 1'b0;
            resp_code_reg <= UCD_RSP_NONE;
            store_reg <= 1'b0;
            store_ep_reg <= '0;
        end
        else
        begin
            resp_valid_reg <= rsp_next != UCD_RSP_NONE;
            resp_code_reg <= rsp_next;
            store_reg <= setup_take;
            store_ep_reg <= setup_take ? ep : store_ep_reg;
        end
    end

    // ------------------------------------------------------------
    // isochronous endpoints
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_EP; i++)
    begin : g_iso
        assign iso_vec[i] = cfg_reg[i*UCD_CFG_STRIDE+UCD_CFG_ISO_BIT];
        ucd_iso_ep u_iso (
            .core_clk(core_clk),
            .reset(reset),
            .arm(fetch_good[i] & iso_vec[i]),
            .cancel(flush_vec[i]),
            .sof(sof_i),
            .is_tx(is_in),
            .head_ppf(cfg_reg[i*UCD_CFG_STRIDE+UCD_CFG_PPF_LSB+:2]),
            .ovr_ppf(ovr_reg[2*i+:2]),
            .pkt(iso_pkt_vec[i]),
            .non_mdata(tok_i.non_mdata),
            .crc_err(tok_i.crc_err),
            .overflow(tok_i.overflow),
            .next_linked(next_linked_i[i]),
            .primed(iso_primed[i]),
            .retire(iso_ret[i]),
            .txn_err(iso_terr[i]),
            .buf_err(iso_berr[i])
        );
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign prime_pending_o = prime_reg;
    assign resp_valid_o = resp_valid_reg;
    assign resp_code_o = resp_code_reg;
    assign setup_store_o = store_reg;
    assign setup_store_ep_o = store_ep_reg;
    assign iso_retire_o = iso_ret;
    assign sys_error_o = sys_err_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_lock_ignore;
        tok_setup && !mode_reg && sstat_reg[ep] |=> !setup_store_o && !resp_valid_o;
    endproperty
    a_lock_ignore: assert property (p_lock_ignore) else $error("setup taken under lockout");

    property p_setup_take;
        setup_take |=> setup_store_o && resp_code_o == UCD_RSP_ACK && sstat_reg[$past(ep)];
    endproperty
    a_setup_take: assert property (p_setup_take) else $error("setup not stored and acked");

    property p_trip_clear;
        setup_take |=> !trip_reg;
    endproperty
    a_trip_clear: assert property (p_trip_clear) else $error("tripwire survived a setup");

    property p_unprime;
        setup_take |=> !primed_ctl_reg[$past(ep)];
    endproperty
    a_unprime: assert property (p_unprime) else $error("primed status kept after setup");

    property p_prime_clr;
        fetch_done_i[0] && !wr_prime |=> !prime_pending_o[0];
    endproperty
    a_prime_clr: assert property (p_prime_clr) else $error("prime request not cleared by fetch");

    property p_ctl_primed;
        fetch_good[0] && !iso_vec[0] && !setup_vec[0] && !wr_prime |=> primed_ctl_reg[0] && !prime_pending_o[0];
    endproperty
    a_ctl_primed: assert property (p_ctl_primed) else $error("fetched control prime not shown");

    property p_w1c;
        wr_sstat && wb_dat_i[0] && wb_sel_i[0] && !setup_vec[0] |=> !sstat_reg[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("setup status not cleared by write one");

    property p_iso_nak;
        tok_valid_i && ep_iso |=> resp_code_o != UCD_RSP_NAK;
    endproperty
    a_iso_nak: assert property (p_iso_nak) else $error("isochronous endpoint refused");

    property p_iso_zlp;
        tok_valid_i && ep_iso && is_in && !iso_live |=> resp_valid_o && resp_code_o == UCD_RSP_ZLP;
    endproperty
    a_iso_zlp: assert property (p_iso_zlp) else $error("unprimed isochronous IN not answered");

    property p_ctl_nak;
        tok_valid_i && ep_bit_ok && !ep_iso && is_in && !ep_stall && !ep_primed |=> resp_code_o == UCD_RSP_NAK;
    endproperty
    a_ctl_nak: assert property (p_ctl_nak) else $error("unprimed control IN not refused");

    property p_sys_err;
        setup_fault |=> sys_error_o && resp_code_o == UCD_RSP_SYSFAULT && !setup_store_o;
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("setup overflow not flagged");

    property p_nyet;
        tok_valid_i && ep_bit_ok && !ep_iso && is_out && !ep_stall && ep_primed && !tok_i.overflow
            && !tok_i.more_pkts |=> resp_valid_o && resp_code_o == UCD_RSP_NYET;
    endproperty
    a_nyet: assert property (p_nyet) else $error("last OUT not answered NYET");

    property p_more_ack;
        tok_valid_i && !ep_iso && is_out && !ep_stall && ep_primed && !tok_i.overflow && tok_i.more_pkts
            |=> resp_code_o == UCD_RSP_ACK;
    endproperty
    a_more_ack: assert property (p_more_ack) else $error("OUT with packets left not acked");

    c_setup: cover property (setup_take ##1 setup_store_o);
    c_nyet: cover property (resp_code_o == UCD_RSP_NYET);
    c_iso: cover property (|iso_ret);
    c_lockout: cover property (tok_setup && lock_on);
endmodule

// >>> hw/ucd_pkg.sv
// Purpose: shared constants and types of the endpoint controller
// Assumes: classic wishbone, 32-bit words, byte addresses
// Notes: all registers reset to zero except the isochronous state flop, which resets to UCD_ISO_IDLE
// How it works
// - control endpoints take every setup without overflow unless the lockout is engaged
// - lockout engaged and setup stored: further setups are ignored
// - writing 1 to the lockout-mode bit disables lockout; tripwire used instead
// - setup-received bits clear when software writes 1
// - control prime done: request bit zero, status one; status zero means failure
// - a setup after data-stage priming clears that endpoint's primed status
// - control matrix: setup ack, stall, nak, transmit, receive, bit-stuff error
// - primed control OUT answers NYET, or ACK while packets remain
// - isochronous moves exactly the multiplier count per frame
// - isochronous never NAKs: IN gets zero-length packet, OUT ignored
// - isochronous prime runs next frame, then stays until done or cancelled
// - prime request clears on fetch; start held until next frame start
// - counter zero retires; partial frame sets error, force-retires next frame
// - isochronous descriptor with no activity stays primed
// - isochronous receive CRC error: no retry, error bit, retire
// - transmit counter loads override when nonzero, else head multiplier
// - receive retires on non-MDATA PID; overflow retires with buffer error
// - on retire the next linked descriptor is armed for next frame
package ucd_pkg;
    localparam int UCD_NUM_EP = 4;
    localparam int UCD_EP_W = 2;
    localparam int UCD_AW = 8;
    localparam logic [7:0] UCD_MODE_OFS = 8'h00;
    localparam logic [7:0] UCD_CMD_OFS = 8'h04;
    localparam logic [7:0] UCD_SSTAT_OFS = 8'h08;
    localparam logic [7:0] UCD_PRIME_OFS = 8'h0c;
    localparam logic [7:0] UCD_PRIMED_OFS = 8'h10;
    localparam logic [7:0] UCD_CFG_OFS = 8'h14;
    localparam logic [7:0] UCD_OVR_OFS = 8'h18;
    localparam logic [7:0] UCD_ERR_OFS = 8'h1c;
    localparam int UCD_MODE_LOCK_OFF_BIT = 0;
    localparam int UCD_CMD_TRIP_BIT = 0;
    localparam int UCD_CFG_STRIDE = 4;
    localparam int UCD_CFG_PPF_LSB = 0;
    localparam int UCD_CFG_ISO_BIT = 2;
    localparam int UCD_CFG_STALL_BIT = 3;
    localparam int UCD_ERR_BUF_LSB = 8;
    localparam int UCD_ERR_SYS_BIT = 16;
    localparam logic [31:0] UCD_REG_RESET = 32'h0;

    typedef enum logic [2:0] {UCD_TOK_SETUP = 3'h0, UCD_TOK_IN = 3'h1, UCD_TOK_OUT = 3'h2,
        UCD_TOK_PING = 3'h3, UCD_TOK_BAD = 3'h4} ucd_tok_kind_t;

    typedef enum logic [3:0] {UCD_RSP_NONE = 4'h0, UCD_RSP_ACK = 4'h1, UCD_RSP_NAK = 4'h2,
        UCD_RSP_STALL = 4'h3, UCD_RSP_NYET = 4'h4, UCD_RSP_XMIT = 4'h5, UCD_RSP_RECV = 4'h6,
        UCD_RSP_ZLP = 4'h7, UCD_RSP_BSERR = 4'h8, UCD_RSP_SYSFAULT = 4'h9,
        UCD_RSP_DROP = 4'ha} ucd_resp_t;

    typedef enum logic [2:0] {UCD_ISO_IDLE = 3'b001, UCD_ISO_WAIT = 3'b010,
        UCD_ISO_RUN = 3'b100} ucd_iso_state_t;

    typedef struct packed {
        ucd_tok_kind_t kind;
        logic [UCD_EP_W-1:0] ep;
        logic crc_err;
        logic non_mdata;
        logic underflow;
        logic overflow;
        logic more_pkts;
        logic last;
    } ucd_tok_t;
endpackage

// >>> hw/ucd_iso_ep.sv
// Purpose: one isochronous endpoint sequencer
// Assumes: sof and packet pulses on core_clk
// Notes: retire and error outputs are flops; primed is decoded from the state flop
`timescale 1ns/1ns
module ucd_iso_ep
    import ucd_pkg::*;
(
    input logic core_clk,
    input logic reset,
    input logic arm,
    input logic cancel,
    input logic sof,
    input logic is_tx,
    input logic [1:0] head_ppf,
    input logic [1:0] ovr_ppf,
    input logic pkt,
    input logic non_mdata,
    input logic crc_err,
    input logic overflow,
    input logic next_linked,
    output logic primed,
    output logic retire,
    output logic txn_err,
    output logic buf_err
);
    ucd_iso_state_t state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next, done_reg, done_next;
    logic ret_next, terr_next, berr_next;

    wire [1:0] load_ppf = (is_tx && ovr_ppf != 2'h0) ? ovr_ppf : head_ppf;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = done_reg;
        ret_next = 1'b0;
        terr_next = 1'b0;
        berr_next = 1'b0;
        unique case (state_reg)
            UCD_ISO_IDLE:
                if (arm)
                    state_next = UCD_ISO_WAIT;
            UCD_ISO_WAIT:
                if (cancel)
                    state_next = UCD_ISO_IDLE;
                else if (sof)
                begin
                    state_next = UCD_ISO_RUN;
                    cnt_next = load_ppf;
                    done_next = 2'h0;
                end
            UCD_ISO_RUN:
                if (cancel)
                    state_next = UCD_ISO_IDLE;
                else if (sof && done_reg != 2'h0)
                begin
                    terr_next = 1'b1;
                    ret_next = 1'b1;
                end
                else if (sof)
                    cnt_next = load_ppf;
                else if (pkt)
                begin
                    done_next = done_reg + 2'h1;
                    cnt_next = cnt_reg - 2'h1;
                    berr_next = !is_tx && overflow;
                    terr_next = !is_tx && !overflow && crc_err;
                    ret_next = (!is_tx && (overflow || crc_err || non_mdata)) || cnt_reg <= 2'h1;
                end
        endcase
        if (ret_next)
            state_next = next_linked ? UCD_ISO_WAIT : UCD_ISO_IDLE;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_reg <= UCD_ISO_IDLE;
            cnt_reg <= 2'h0;
            done_reg <= 2'h0;
            retire <= 1'b0;
            txn_err <= 1'b0;
            buf_err <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            retire <= ret_next;
            txn_err <= terr_next;
            buf_err <= berr_next;
        end
    end

    assign primed = (state_reg == UCD_ISO_RUN);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_start_sof;
        state_reg == UCD_ISO_WAIT && !sof ##1 state_reg == UCD_ISO_WAIT && sof && !cancel |=> primed;
    endproperty
    a_start_sof: assert property (p_start_sof) else $error("iso start missed frame start");
    property p_fulfil;
        primed && sof && done_reg != 2'h0 && !cancel |=> retire && txn_err;
    endproperty
    a_fulfil: assert property (p_fulfil) else $error("partial frame not force retired");
    property p_crc;
        primed && !sof && !cancel && pkt && !is_tx && crc_err && !overflow |=> retire && txn_err && !buf_err;
    endproperty
    a_crc: assert property (p_crc) else $error("crc error not retired");
    property p_relink;
        primed && sof && done_reg != 2'h0 && !cancel && next_linked |=> !primed ##1 !primed;
    endproperty
    a_relink: assert property (p_relink) else $error("next descriptor not held to next frame");
    c_retire: cover property (retire && !txn_err);
endmodule

// >>> verification/ucd_host_model.sv
// Purpose: host side of the bus, one token at a time
// Assumes: the bench calls send; lines change after a rising edge
// Notes: idle token lines carry the inverse of the last token
`timescale 1ns/1ns
module ucd_host_model
    import ucd_pkg::*;
(
    input logic core_clk,
    output logic tok_valid,
    output ucd_tok_t tok
);
    initial
    begin
        tok_valid = 1'b0;
        tok = ucd_tok_t'(11'h0);
    end
    task send(input ucd_tok_t t);
        @(posedge core_clk);
        tok_valid <= 1'b1;
        tok <= t;
        @(posedge core_clk);
        tok_valid <= 1'b0;
        tok <= ucd_tok_t'(~t);
    endtask
endmodule

// >>> verification/ucd_ep_ctrl_tb_top.sv
// Purpose: self-checking bench of the endpoint controller
// Assumes: host model sends tokens, bench drives wishbone and strobes
// Notes: each answer is looked for within three cycles
`timescale 1ns/1ns
module ucd_ep_ctrl_tb_top
    import ucd_pkg::*;
;
    typedef struct packed {logic [31:0] cfg; ucd_tok_t t; ucd_resp_t r;} ucd_tb_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sof = 1'b0, tok_valid;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, wb_dat_o;
    logic [3:0] fdone = 4'h0, fok = 4'h0, nlink = 4'h0, pend, iso_ret, rt;
    logic [2:0] st;
    logic wb_ack_o, resp_valid_o, setup_store_o, sys_error_o;
    logic [1:0] setup_store_ep_o;
    ucd_tok_t tok;
    ucd_resp_t resp_code_o;
    ucd_tb_row_t rows [9];
    int errors = 0, cmp_count = 0, i;
    always #2 core_clk = ~core_clk;
    ucd_host_model u_ucd_host_model (.core_clk(core_clk), .tok_valid(tok_valid), .tok(tok));
    ucd_ep_ctrl u_ucd_ep_ctrl (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tok_valid_i(tok_valid), .tok_i(tok), .sof_i(sof), .fetch_done_i(fdone),
        .fetch_ok_i(fok), .next_linked_i(nlink), .prime_pending_o(pend), .resp_valid_o(resp_valid_o),
        .resp_code_o(resp_code_o), .setup_store_o(setup_store_o), .setup_store_ep_o(setup_store_ep_o),
        .iso_retire_o(iso_ret), .sys_error_o(sys_error_o));
    task give_verdict;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 20)
            errors++;
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task tk(input ucd_tok_t t, input ucd_resp_t e);
        logic [3:0] got;
        got = 4'h0;
        st = 3'h0;
        rt = 4'h0;
        u_ucd_host_model.send(t);
        repeat (3)
        begin
            @(posedge core_clk);
            if (resp_valid_o === 1'b1)
                got = resp_code_o;
            if (setup_store_o === 1'b1)
                st = {1'b1, setup_store_ep_o};
            rt = rt | iso_ret;
        end
        chk(got, e);
    endtask
    task strobe(input logic [3:0] f, input logic s);
        @(posedge core_clk);
        fdone <= f;
        fok <= f;
        sof <= s;
        @(posedge core_clk);
        fdone <= 4'h0;
        sof <= 1'b0;
    endtask
    function ucd_tok_t mk(input ucd_tok_kind_t k, input logic [1:0] e, input logic [5:0] f);
        return ucd_tok_t'({k, e, f});
    endfunction
    initial
    begin
        #40000;
        errors++;
        give_verdict();
    end
    initial
    begin
        rows = '{'{32'h0, mk(UCD_TOK_IN, 2'h0, 6'h0), UCD_RSP_NAK}, '{32'h0, mk(UCD_TOK_OUT, 2'h0, 6'h0), UCD_RSP_NAK},
            '{32'h0, mk(UCD_TOK_PING, 2'h0, 6'h0), UCD_RSP_NAK}, '{32'h8, mk(UCD_TOK_IN, 2'h0, 6'h0), UCD_RSP_STALL},
            '{32'h8, mk(UCD_TOK_OUT, 2'h0, 6'h0), UCD_RSP_STALL}, '{32'h8, mk(UCD_TOK_PING, 2'h0, 6'h0), UCD_RSP_STALL},
            '{32'h0, mk(UCD_TOK_BAD, 2'h0, 6'h0), UCD_RSP_NONE}, '{32'h4, mk(UCD_TOK_IN, 2'h0, 6'h0), UCD_RSP_ZLP},
            '{32'h4, mk(UCD_TOK_OUT, 2'h0, 6'h0), UCD_RSP_NONE}};
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        chk(wb_ack_o, 1'b0);
        for (i = 0; i < 9; i++)
        begin
            wbx(1'b1, UCD_CFG_OFS, rows[i].cfg);
            tk(rows[i].t, rows[i].r);
        end
        tk(mk(UCD_TOK_SETUP, 2'h1, 6'h0), UCD_RSP_ACK);
        chk(st, 3'h5);
        rchk(UCD_SSTAT_OFS, 32'h2);
        tk(mk(UCD_TOK_SETUP, 2'h1, 6'h0), UCD_RSP_NONE);
        chk(st, 3'h0);
        wbx(1'b1, UCD_SSTAT_OFS, 32'h2);
        rchk(UCD_SSTAT_OFS, 32'h0);
        wbx(1'b1, UCD_MODE_OFS, 32'h1);
        wbx(1'b1, UCD_CMD_OFS, 32'h1);
        tk(mk(UCD_TOK_SETUP, 2'h1, 6'h0), UCD_RSP_ACK);
        tk(mk(UCD_TOK_SETUP, 2'h1, 6'h0), UCD_RSP_ACK);
        rchk(UCD_CMD_OFS, 32'h0);
        wbx(1'b1, UCD_CFG_OFS, 32'h0);
        wbx(1'b1, UCD_PRIME_OFS, 32'h1);
        rchk(UCD_PRIME_OFS, 32'h1);
        chk(pend, 4'h1);
        strobe(4'h1, 1'b0);
        rchk(UCD_PRIME_OFS, 32'h0);
        rchk(UCD_PRIMED_OFS, 32'h1);
        rchk(UCD_SSTAT_OFS, 32'h2);
        tk(mk(UCD_TOK_OUT, 2'h0, 6'h0), UCD_RSP_NYET);
        tk(mk(UCD_TOK_OUT, 2'h0, 6'h2), UCD_RSP_ACK);
        tk(mk(UCD_TOK_PING, 2'h0, 6'h0), UCD_RSP_ACK);
        tk(mk(UCD_TOK_IN, 2'h0, 6'h0), UCD_RSP_XMIT);
        tk(mk(UCD_TOK_SETUP, 2'h0, 6'h0), UCD_RSP_ACK);
        rchk(UCD_PRIMED_OFS, 32'h0);
        wbx(1'b1, UCD_PRIME_OFS, 32'h1);
        strobe(4'h1, 1'b0);
        tk(mk(UCD_TOK_IN, 2'h0, 6'h1), UCD_RSP_XMIT);
        rchk(UCD_PRIMED_OFS, 32'h0);
        tk(mk(UCD_TOK_SETUP, 2'h0, 6'h4), UCD_RSP_SYSFAULT);
        chk(sys_error_o, 1'b1);
        wbx(1'b1, UCD_CFG_OFS, 32'h500);
        wbx(1'b1, UCD_PRIME_OFS, 32'h4);
        strobe(4'h4, 1'b0);
        rchk(UCD_PRIME_OFS, 32'h0);
        rchk(UCD_PRIMED_OFS, 32'h0);
        strobe(4'h0, 1'b1);
        rchk(UCD_PRIMED_OFS, 32'h4);
        tk(mk(UCD_TOK_IN, 2'h2, 6'h0), UCD_RSP_XMIT);
        chk(rt, 4'h4);
        rchk(UCD_PRIMED_OFS, 32'h0);
        wbx(1'b1, UCD_CFG_OFS, 32'h600);
        wbx(1'b1, UCD_PRIME_OFS, 32'h4);
        strobe(4'h4, 1'b0);
        strobe(4'h0, 1'b1);
        tk(mk(UCD_TOK_IN, 2'h2, 6'h0), UCD_RSP_XMIT);
        chk(rt, 4'h0);
        nlink <= 4'h4;
        strobe(4'h0, 1'b1);
        rchk(UCD_ERR_OFS, 32'h10004);
        rchk(UCD_PRIMED_OFS, 32'h0);
        repeat (2) strobe(4'h0, 1'b1);
        rchk(UCD_PRIMED_OFS, 32'h4);
        tk(mk(UCD_TOK_OUT, 2'h2, 6'h20), UCD_RSP_RECV);
        chk(rt, 4'h4);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        chk(sys_error_o, 1'b0);
        rchk(UCD_SSTAT_OFS, 32'h0);
        give_verdict();
    end
endmodule
